// file: testbench.sv
// self-checking endpoint control bench
module testbench
   import usbl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} usbl_row_type;
   logic           sys_clk = 1'b0;
   logic           sys_rst = 1'b1;
   logic           ce = 1'b1;
   logic [7:0]     regAddr = 8'h00, regWdata = 8'h00, memAddr = 8'h00, memWdata = 8'h00;
   logic           regWr = 1'b0, regRd = 1'b0, memWr = 1'b0, memRd = 1'b0, setupSeen = 1'b0;
   logic [7:0]     regRdata, memRdata, rxByte, txByte;
   logic [3:0]     tokEp, dataLen, txCount;
   logic [2:0]     rxIdx, txIdx;
   logic           tokStb, dataStb, dataErr, dataToggle, hostAck, rxWr, dPlusIn, dMinusIn;
   logic           replyStb, txEp, txToggle, rxStore, driveResumeLevel, driveIdleLevel;
   logic           ep0Irq, ep1Irq;
   usbl_tok_type   tokType;
   usbl_reply_type replyCode;
   int             err_count = 0;
   int             check_count = 0;
   usbl_row_type   rows[12] = '{'{0, 8'h10, 8'h00}, '{0, 8'h11, 8'h00}, '{0, 8'h13, 8'h00},
      '{1, 8'h10, 8'h5a}, '{0, 8'h10, 8'h5a}, '{1, 8'h11, 8'h6f}, '{0, 8'h11, 8'h6f},
      '{1, 8'h13, 8'he7}, '{0, 8'h13, 8'h06}, '{1, 8'h12, 8'hff}, '{0, 8'h12, 8'h00},
      '{1, 8'h13, 8'h00}};

   always #2.5 sys_clk = ~sys_clk;
   usbl_ep_ctrl i_usbl_ep_ctrl (.*);
   usbl_host_model host (.*);
   ////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle strobe; a read compares the next cycle
   task automatic bus(input logic m, input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      {memWr, memRd, regWr, regRd} <= {m & w, m & ~w, ~m & w, ~m & ~w};
      {memAddr, regAddr, memWdata, regWdata} <= {a, a, d, d};
      @(posedge sys_clk);
      {memWr, memRd, regWr, regRd} <= 4'h0;
      #1;
      if (!w) chk(m ? memRdata : regRdata, d);
   endtask
   task automatic rep(input logic s, input usbl_reply_type c);
      #1;
      chk({7'h0, replyStb}, {7'h0, s});
      if (s) chk({6'h0, replyCode}, {6'h0, c});
   endtask
   task automatic tx(input logic [7:0] e);
      chk({txEp, txToggle, 2'h0, txCount}, e);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      $display("Error at %0t: timeout got %h expected %h", $time, 1'b0, 1'b1);
      complete_run();
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      foreach (rows[i]) bus(1'b0, rows[i].w, rows[i].a, rows[i].d);
      // force J one step before K
      bus(1'b0, 1'b1, USBL_ADDR_SCR, 8'h04);
      chk({6'h0, driveIdleLevel, driveResumeLevel}, 8'h02);
      bus(1'b0, 1'b1, USBL_ADDR_SCR, 8'h02);
      chk({6'h0, driveIdleLevel, driveResumeLevel}, 8'h01);
      bus(1'b0, 1'b1, USBL_ADDR_SCR, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 3; i++) bus(1'b1, 1'b1, USBL_FIFO0_BASE + 8'(i), 8'ha0 + 8'(i));
      bus(1'b0, 1'b1, USBL_ADDR_EP0_TX, 8'h43);
      bus(1'b0, 1'b1, USBL_ADDR_EP0_TX, 8'hc3);
      host.sel(3'h2);
      host.tok(USBL_TOK_IN, USBL_EP0);
      rep(1'b1, USBL_RPL_DATA);
      tx(8'h43);
      @(posedge sys_clk);
      #1 chk(txByte, 8'ha2);
      host.ack();
      #1 chk({7'h0, ep0Irq}, 8'h01);
      bus(1'b0, 1'b0, USBL_ADDR_EP0_TX, 8'h43);
      bus(1'b0, 1'b1, USBL_ADDR_EP0_TX, 8'ha0);
      host.tok(USBL_TOK_IN, USBL_EP0);
      rep(1'b1, USBL_RPL_STALL);
      host.tok(USBL_TOK_OUT, USBL_EP0);
      host.dat(1'b0, 1'b0, 4'h0);
      rep(1'b1, USBL_RPL_STALL);
      bus(1'b0, 1'b1, USBL_ADDR_SCR, 8'h18);
      host.tok(USBL_TOK_SETUP, USBL_EP0);
      host.dat(1'b0, 1'b0, 4'h8);
      rep(1'b1, USBL_RPL_ACK);
      bus(1'b0, 1'b0, USBL_ADDR_EP0_TX, 8'h00);
      bus(1'b0, 1'b0, USBL_ADDR_SCR, 8'h00);
      host.tok(USBL_TOK_SETUP, USBL_EP0);
      host.dat(1'b1, 1'b0, 4'h8);
      rep(1'b0, USBL_RPL_ACK);
      bus(1'b0, 1'b0, USBL_ADDR_EP0_TX, 8'h10);
      @(posedge sys_clk);
      setupSeen <= 1'b1;
      bus(1'b1, 1'b1, USBL_FIFO0_BASE, 8'h55);
      setupSeen <= 1'b0;
      bus(1'b1, 1'b0, USBL_FIFO0_BASE, 8'ha0);
      $display("test control in done");
      bus(1'b0, 1'b1, USBL_ADDR_SCR, 8'h10);
      host.tok(USBL_TOK_OUT, USBL_EP0);
      #1 chk({7'h0, rxStore}, 8'h01);
      host.put(3'h3, 8'h77);
      host.dat(1'b0, 1'b0, 4'h1);
      rep(1'b1, USBL_RPL_ACK);
      bus(1'b0, 1'b0, USBL_ADDR_SCR, 8'h00);
      bus(1'b1, 1'b0, USBL_FIFO0_BASE + 8'h03, 8'h77);
      host.tok(USBL_TOK_OUT, USBL_EP0);
      host.dat(1'b0, 1'b0, 4'h1);
      rep(1'b1, USBL_RPL_NAK);
      bus(1'b0, 1'b1, USBL_ADDR_SCR, 8'h08);
      host.tok(USBL_TOK_OUT, USBL_EP0);
      host.put(3'h4, 8'h99);
      host.dat(1'b0, 1'b1, USBL_STATUS_LEN);
      rep(1'b1, USBL_RPL_ACK);
      bus(1'b1, 1'b0, USBL_FIFO0_BASE + 8'h04, 8'h00);
      host.tok(USBL_TOK_OUT, USBL_EP0);
      host.dat(1'b0, 1'b1, 4'h2);
      rep(1'b1, USBL_RPL_STALL);
      bus(1'b0, 1'b0, USBL_ADDR_SCR, 8'h08);
      $display("test control out done");
      bus(1'b1, 1'b1, USBL_FIFO1_BASE, 8'hb1);
      bus(1'b0, 1'b1, USBL_ADDR_EP1_TX, 8'h81);
      host.tok(USBL_TOK_IN, USBL_EP1);
      rep(1'b0, USBL_RPL_ACK);
      bus(1'b0, 1'b1, USBL_ADDR_EP1_TX, 8'hd1);
      host.sel(3'h0);
      host.tok(USBL_TOK_IN, USBL_EP1);
      rep(1'b1, USBL_RPL_DATA);
      tx(8'hc1);
      @(posedge sys_clk);
      #1 chk(txByte, 8'hb1);
      host.ack();
      #1 chk({7'h0, ep1Irq}, 8'h01);
      bus(1'b0, 1'b0, USBL_ADDR_EP1_TX, 8'h51);
      bus(1'b0, 1'b1, USBL_ADDR_EP1_TX, 8'h30);
      host.tok(USBL_TOK_OUT, USBL_EP1);
      rep(1'b1, USBL_RPL_STALL);
      host.tok(USBL_TOK_IN, USBL_EP1);
      rep(1'b1, USBL_RPL_STALL);
      $display("test second endpoint done");
      host.pins(1'b1, 1'b0);
      repeat (4) @(posedge sys_clk);
      host.pins(1'b0, 1'b1);
      repeat (4) @(posedge sys_clk);
      bus(1'b0, 1'b1, USBL_ADDR_SCR, 8'h09);
      bus(1'b0, 1'b0, USBL_ADDR_SCR, 8'h09);
      bus(1'b0, 1'b1, USBL_ADDR_SCR, 8'h08);
      bus(1'b0, 1'b0, USBL_ADDR_SCR, 8'h08);
      $display("test activity done");
      complete_run();
   end
endmodule

// file: usbl_ep_ctrl.sv
// endpoint transmit control and bus status/control logic of the serial engine
//
// Operation
// R1: ctrl_ep_tx_config read/write at 0x10, all bits zero after reset.
// R2: low four bits give IN byte count; firmware programs 0 to 8.
// R3: bit 4 set when SETUP or OUT data packet has CRC, PID or stuff fault.
// R4: stall bit 5 answers IN and OUT with STALL; SETUP clears it.
// R5: bit 6 selects DATA0 or DATA1 for transmitted packet; firmware keeps toggle.
// R6: armed bit 7 answers next IN; host ACK clears it, pulses irq; SETUP clears.
// R7: firmware fills FIFO, sets toggle, then arms bit 7.
// R8: second endpoint transmits only, from eight-byte FIFO at 0x78 to 0x7f.
// R9: second_ep_tx_config read/write at 0x11, all bits zero after reset.
// R10: second endpoint low four bits give IN byte count, 0 to 8.
// R11: second endpoint ignores all traffic while bit 4 is clear.
// R12: second endpoint stall bit 5 answers IN and OUT with STALL until cleared.
// R13: second endpoint bit 6 selects DATA0 or DATA1.
// R14: host ACK on second endpoint clears its arm bit and pulses irq.
// R15: bus_status_control at 0x13, zero after reset, upper three bits reserved.
// R16: bit 0 set on non-idle bus; writing zero clears, one keeps.
// R17: firmware polls and clears activity bit to notice bus loss.
// R18: bit 1 forces K (resume), bit 2 forces J on transmitter.
// R19: firmware keeps force-J low, forces J one instruction before K.
// R20: status bit 3 ACKs zero-length DATA1 OUT, STALLs others, no FIFO store.
// R21: bit 4 stores OUT data, else NAK; SETUP or ACKed OUT clears it.
// R22: control endpoint shares one eight-byte FIFO at 0x70 to 0x77.
// R23: firmware FIFO writes blocked while received-SETUP flag is set.
// R24: endpoint irq is one-cycle pulse when arm bit clears after host ACK.
//
// Implementation choice: the plain strobed port.

module usbl_ep_ctrl
   import usbl_pkg::*;
(
   input  logic                 sys_clk,
   input  logic                 sys_rst,
   input  logic                 ce,
   input  logic [7:0]           regAddr,
   input  logic [7:0]           regWdata,
   input  logic                 regWr,
   input  logic                 regRd,
   output logic [7:0]           regRdata,
   input  logic [7:0]           memAddr,
   input  logic [7:0]           memWdata,
   input  logic                 memWr,
   input  logic                 memRd,
   output logic [7:0]           memRdata,
   input  logic                 setupSeen,
   input  logic                 dPlusIn,
   input  logic                 dMinusIn,
   input  logic                 tokStb,
   input  usbl_tok_type         tokType,
   input  logic [3:0]           tokEp,
   input  logic                 dataStb,
   input  logic                 dataErr,
   input  logic                 dataToggle,
   input  logic [3:0]           dataLen,
   input  logic                 hostAck,
   input  logic                 rxWr,
   input  logic [2:0]           rxIdx,
   input  logic [7:0]           rxByte,
   input  logic [2:0]           txIdx,
   output logic                 replyStb,
   output usbl_reply_type       replyCode,
   output logic                 txEp,
   output logic                 txToggle,
   output logic [3:0]           txCount,
   output logic [7:0]           txByte,
   output logic                 rxStore,
   output logic                 driveResumeLevel,
   output logic                 driveIdleLevel,
   output logic                 ep0Irq,
   output logic                 ep1Irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0]     ctrlEpTx_r;
   logic [7:0]     secondEpTx_r;
   logic [7:0]     busStatus_r;
   usbl_state_type state_r;
   usbl_state_type state_nxt;
   logic           dataSetup_r;
   logic           ackEp1_r;
   logic           rxAllow_r;
   logic           replyStb_r;
   usbl_reply_type replyCode_r;
   logic           txEp_r;
   logic           txToggle_r;
   logic [3:0]     txCount_r;
   logic [7:0]     txByte_r;
   logic [7:0]     regRdata_r;
   logic [7:0]     memRdata_r;
   logic           ep0Irq_r;
   logic           ep1Irq_r;
   logic           dpS1_r;
   logic           dpS2_r;
   logic           dmS1_r;
   logic           dmS2_r;
   logic [7:0]     fifo_r [USBL_FIFO_TOTAL];

   ////////////////////////////////////////////////////////////////////////////////
   // token decode
   wire isEp0      = (tokEp == USBL_EP0);
   wire isEp1      = (tokEp == USBL_EP1);
   // R11 second endpoint ignored while disabled
   wire ep1Live    = isEp1 && secondEpTx_r[USBL_ON_BIT];
   wire tokSetup   = tokStb && (tokType == USBL_TOK_SETUP) && isEp0;
   wire tokOut0    = tokStb && (tokType == USBL_TOK_OUT) && isEp0;
   wire tokOut1    = tokStb && (tokType == USBL_TOK_OUT) && ep1Live;
   wire tokIn0     = tokStb && (tokType == USBL_TOK_IN) && isEp0;
   wire tokIn1     = tokStb && (tokType == USBL_TOK_IN) && ep1Live;
   wire tokInAny   = tokIn0 || tokIn1;

   wire stall0     = ctrlEpTx_r[USBL_STL_BIT];
   wire stall1     = secondEpTx_r[USBL_STL_BIT];
   wire armed0     = ctrlEpTx_r[USBL_ARM_BIT];
   wire armed1     = secondEpTx_r[USBL_ARM_BIT];
   wire auto_handshake_flag = busStatus_r[USBL_STA_BIT];
   wire accept_host_writes_flag = busStatus_r[USBL_ACC_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // immediate replies to IN and second endpoint OUT
   // R4 stall on control endpoint
   wire usbl_reply_type in0Code =
      stall0 ? USBL_RPL_STALL : (armed0 ? USBL_RPL_DATA : USBL_RPL_NAK);
   // R12 stall on second endpoint
   wire usbl_reply_type in1Code =
      stall1 ? USBL_RPL_STALL : (armed1 ? USBL_RPL_DATA : USBL_RPL_NAK);
   // second endpoint cannot receive, so OUT there is refused
   wire usbl_reply_type out1Code = stall1 ? USBL_RPL_STALL : USBL_RPL_NAK;

   wire usbl_reply_type tokCode =
      tokIn0 ? in0Code : (tokIn1 ? in1Code : out1Code);
   wire tokReply   = tokIn0 || tokIn1 || tokOut1;
   // R6 armed IN sends loaded data
   wire sendData   = (tokIn0 && (in0Code == USBL_RPL_DATA))
                  || (tokIn1 && (in1Code == USBL_RPL_DATA));

   ////////////////////////////////////////////////////////////////////////////////
   // data phase decision
   wire inData     = (state_r == USBL_ST_DATAWAIT) && dataStb;
   wire statusOk   = dataToggle && (dataLen == USBL_STATUS_LEN);
   // R20 status stage handshake
   wire usbl_reply_type statCode = statusOk ? USBL_RPL_ACK : USBL_RPL_STALL;
   // R21 accept or NAK OUT data
   wire usbl_reply_type outCode =
      stall0     ? USBL_RPL_STALL :
      auto_handshake_flag ? statCode :
      accept_host_writes_flag ? USBL_RPL_ACK : USBL_RPL_NAK;
   wire usbl_reply_type dataCode = dataSetup_r ? USBL_RPL_ACK : outCode;
   // corrupt data packets get no handshake
   wire dataReply  = inData && !dataErr;
   // R3 receive error flag
   wire errSet     = inData && dataErr;
   wire outAcked   = dataReply && !dataSetup_r && (outCode == USBL_RPL_ACK);
   // R22 setup data always lands, OUT data only when accepting
   wire allowOut   = !stall0 && !auto_handshake_flag && accept_host_writes_flag;

   ////////////////////////////////////////////////////////////////////////////////
   // host acknowledge of our data
   wire ackHit     = (state_r == USBL_ST_ACKWAIT) && hostAck && !tokStb;
   wire ack0       = ackHit && !ackEp1_r;
   wire ack1       = ackHit && ackEp1_r;

   // a new token always restarts the transaction tracker
   assign state_nxt =
      (tokSetup || tokOut0) ? USBL_ST_DATAWAIT :
      sendData              ? USBL_ST_ACKWAIT  :
      tokStb                ? USBL_ST_IDLE     :
      (inData || ackHit)    ? USBL_ST_IDLE     : state_r;

   ////////////////////////////////////////////////////////////////////////////////
   // register writes merged with hardware updates
   wire wrEp0      = regWr && (regAddr == USBL_ADDR_EP0_TX);
   wire wrEp1      = regWr && (regAddr == USBL_ADDR_EP1_TX);
   wire wrScr      = regWr && (regAddr == USBL_ADDR_SCR);

   wire [7:0] ep0Base = wrEp0 ? regWdata : ctrlEpTx_r;
   wire [7:0] ep1Base = wrEp1 ? regWdata : secondEpTx_r;
   wire [7:0] scrBase = wrScr ? (regWdata & USBL_SCR_MASK) : busStatus_r;

   // R1 control endpoint register next value
   wire [7:0] ctrlEpTx_nxt = {
      // R6 arm cleared by ack or setup
      ep0Base[USBL_ARM_BIT] && !tokSetup && !ack0,
      ep0Base[USBL_TOG_BIT],
      // R4 setup clears stall
      ep0Base[USBL_STL_BIT] && !tokSetup,
      // R3 hardware set beats firmware clear
      ep0Base[USBL_ERR_BIT] || errSet,
      ep0Base[USBL_CNT_MSB:USBL_CNT_LSB]
   };

   // R9 second endpoint register next value
   wire [7:0] secondEpTx_nxt = {
      // R14 arm cleared by host ack
      ep1Base[USBL_ARM_BIT] && !ack1,
      ep1Base[USBL_ARM_BIT-1:USBL_CNT_LSB]
   };

   // R16 bus activity, idle is D+ low with D- high
   wire lineActive = dpS2_r || !dmS2_r;
   wire actKeep    = wrScr ? (busStatus_r[USBL_ACT_BIT] && regWdata[USBL_ACT_BIT])
                           : busStatus_r[USBL_ACT_BIT];

   // R15 status and control next value
   wire [7:0] busStatus_nxt = {
      scrBase[7:USBL_ACC_BIT+1],
      // R21 cleared by setup or acked OUT
      scrBase[USBL_ACC_BIT] && !tokSetup && !outAcked,
      // R20 cleared by setup
      scrBase[USBL_STA_BIT] && !tokSetup,
      scrBase[USBL_J_BIT],
      scrBase[USBL_K_BIT],
      actKeep || lineActive
   };

   ////////////////////////////////////////////////////////////////////////////////
   // read decode, unmapped addresses read zero
   wire [7:0] regReadVal =
      (regAddr == USBL_ADDR_EP0_TX) ? ctrlEpTx_r   :
      (regAddr == USBL_ADDR_EP1_TX) ? secondEpTx_r :
      (regAddr == USBL_ADDR_SCR)    ? busStatus_r  : USBL_READ_ZERO;

   ////////////////////////////////////////////////////////////////////////////////
   // fifo addressing
   wire       fwHit    = (memAddr[7:4] == USBL_FIFO_PAGE);
   wire [3:0] fwIdx    = memAddr[3:0];
   // R23 firmware writes blocked while setup data is held
   wire       fwWrOk   = memWr && fwHit && !setupSeen;
   // R22 engine writes only the control endpoint half
   wire       rxWrOk   = rxWr && rxAllow_r;
   wire [3:0] rxSlot   = {1'b0, rxIdx};
   // R8 second endpoint reads from upper half
   wire [3:0] txSlot   = {txEp_r, txIdx};
   wire [7:0] memReadVal = fwHit ? fifo_r[fwIdx] : USBL_READ_ZERO;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dpS1_r <= 1'b0;
         dpS2_r <= 1'b0;
         dmS1_r <= 1'b1;
         dmS2_r <= 1'b1;
      end else if (ce) begin
         dpS1_r <= dPlusIn;
         dpS2_r <= dpS1_r;
         dmS1_r <= dMinusIn;
         dmS2_r <= dmS1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrlEpTx_r   <= USBL_RESET_VALUE;
         secondEpTx_r <= USBL_RESET_VALUE;
         busStatus_r  <= USBL_RESET_VALUE;
      end else if (ce) begin
         ctrlEpTx_r   <= ctrlEpTx_nxt;
         secondEpTx_r <= secondEpTx_nxt;
         busStatus_r  <= busStatus_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transaction tracker
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r     <= USBL_ST_IDLE;
         dataSetup_r <= 1'b0;
         ackEp1_r    <= 1'b0;
         rxAllow_r   <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         if (tokStb) begin
            dataSetup_r <= tokSetup;
            ackEp1_r    <= tokIn1;
            rxAllow_r   <= tokSetup || (tokOut0 && allowOut);
         end else if (inData) begin
            rxAllow_r   <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // handshake and transmit outputs
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         replyStb_r  <= 1'b0;
         replyCode_r <= USBL_RPL_NAK;
         txEp_r      <= 1'b0;
         txToggle_r  <= 1'b0;
         txCount_r   <= 4'h0;
      end else if (ce) begin
         replyStb_r <= tokReply || dataReply;
         if (tokReply) begin
            replyCode_r <= tokCode;
         end else if (dataReply) begin
            replyCode_r <= dataCode;
         end
         // R2 R5 R10 R13 toggle and count latched at the IN
         if (tokInAny) begin
            txEp_r     <= tokIn1;
            txToggle_r <= tokIn1 ? secondEpTx_r[USBL_TOG_BIT] : ctrlEpTx_r[USBL_TOG_BIT];
            txCount_r  <= tokIn1 ? secondEpTx_r[USBL_CNT_MSB:USBL_CNT_LSB]
                                 : ctrlEpTx_r[USBL_CNT_MSB:USBL_CNT_LSB];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt pulses and read data
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ep0Irq_r   <= 1'b0;
         ep1Irq_r   <= 1'b0;
         regRdata_r <= USBL_READ_ZERO;
         memRdata_r <= USBL_READ_ZERO;
         txByte_r   <= USBL_READ_ZERO;
      end else if (ce) begin
         // R24 one pulse as the arm bit drops
         ep0Irq_r   <= ack0;
         ep1Irq_r   <= ack1;
         regRdata_r <= regRd ? regReadVal : USBL_READ_ZERO;
         memRdata_r <= memRd ? memReadVal : USBL_READ_ZERO;
         txByte_r   <= fifo_r[txSlot];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // fifo storage, engine write wins over firmware in the same slot
   for (genvar g = 0; g < USBL_FIFO_TOTAL; g++) begin : gFifo
      localparam logic [3:0] SLOT = 4'(g);
      wire rxHit = rxWrOk && (rxSlot == SLOT);
      wire fwSel = fwWrOk && (fwIdx == SLOT);
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            fifo_r[g] <= USBL_READ_ZERO;
         end else if (ce) begin
            // R22 received data may overwrite
            if (rxHit) begin
               fifo_r[g] <= rxByte;
            // R23 gated firmware store
            end else if (fwSel) begin
               fifo_r[g] <= memWdata;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign regRdata         = regRdata_r;
   assign memRdata         = memRdata_r;
   assign replyStb         = replyStb_r;
   assign replyCode        = replyCode_r;
   assign txEp             = txEp_r;
   assign txToggle         = txToggle_r;
   assign txCount          = txCount_r;
   assign txByte           = txByte_r;
   assign rxStore          = rxAllow_r;
   // R18 forced line states straight from the register
   assign driveResumeLevel = busStatus_r[USBL_K_BIT];
   assign driveIdleLevel   = busStatus_r[USBL_J_BIT];
   assign ep0Irq           = ep0Irq_r;
   assign ep1Irq           = ep1Irq_r;

endmodule

// file: usbl_ep_ctrl_chk.sv
// endpoint control port checks
module usbl_ep_ctrl_chk
   import usbl_pkg::*;
(
   input logic           sys_clk,
   input logic           sys_rst,
   input logic [7:0]     regAddr,
   input logic [7:0]     regWdata,
   input logic           regWr,
   input logic           regRd,
   input logic [7:0]     regRdata,
   input logic           tokStb,
   input usbl_tok_type   tokType,
   input logic [3:0]     tokEp,
   input logic           dataStb,
   input logic           dataErr,
   input logic           hostAck,
   input logic           replyStb,
   input usbl_reply_type replyCode,
   input logic           txEp,
   input logic           rxStore,
   input logic           driveResumeLevel,
   input logic           driveIdleLevel,
   input logic           ep0Irq,
   input logic           ep1Irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   a_irq0_pulse: assert property (ep0Irq |=> !ep0Irq)
      else $error("irq0 width");
   a_irq0_cause: assert property (ep0Irq |-> $past(hostAck) && !txEp)
      else $error("irq0 cause");
   a_irq1_cause: assert property (ep1Irq |-> $past(hostAck) && txEp)
      else $error("irq1 cause");
   a_in_answer: assert property (tokStb && tokType == USBL_TOK_IN && tokEp == USBL_EP0
      |=> replyStb) else $error("IN unanswered");
   a_data_cause: assert property (replyStb && replyCode == USBL_RPL_DATA
      |-> $past(tokStb) && $past(tokType) == USBL_TOK_IN) else $error("data without IN");
   a_err_quiet: assert property (dataStb && dataErr |=> !replyStb)
      else $error("faulty reply");
   a_setup_store: assert property (tokStb && tokType == USBL_TOK_SETUP && tokEp == USBL_EP0
      |=> rxStore) else $error("setup refused");
   a_force_k: assert property ($rose(driveResumeLevel) |-> $past(regWr)
      && $past(regAddr) == USBL_ADDR_SCR && $past(regWdata[USBL_K_BIT])) else $error("bad K");
   a_force_j: assert property ($rose(driveIdleLevel) |-> $past(regWr)
      && $past(regAddr) == USBL_ADDR_SCR && $past(regWdata[USBL_J_BIT])) else $error("bad J");
   a_rdata_idle: assert property (!$past(regRd) |-> regRdata == USBL_READ_ZERO)
      else $error("stray rdata");
   a_reserved_zero: assert property ($past(regRd) && $past(regAddr) == USBL_ADDR_SCR
      |-> regRdata[7:5] == 3'h0) else $error("reserved bits set");
   ////////////////////////////////////////
   c_ack0: cover property (ep0Irq);
   c_ack1: cover property (ep1Irq);
   c_stall: cover property (replyStb && replyCode == USBL_RPL_STALL);
endmodule

bind usbl_ep_ctrl usbl_ep_ctrl_chk i_usbl_ep_ctrl_chk (.*);

// file: usbl_host_model.sv
// behavioural low-speed host at the engine strobes
module usbl_host_model
   import usbl_pkg::*;
(
   input  logic         sys_clk,
   output usbl_tok_type tokType,
   output logic [3:0]   tokEp,
   output logic [3:0]   dataLen,
   output logic [7:0]   rxByte,
   output logic [2:0]   rxIdx,
   output logic [2:0]   txIdx,
   output logic         tokStb,
   output logic         dataStb,
   output logic         dataErr,
   output logic         dataToggle,
   output logic         hostAck,
   output logic         rxWr,
   output logic         dPlusIn,
   output logic         dMinusIn
);
   initial begin
      {tokStb, dataStb, dataErr, dataToggle, hostAck, rxWr, dPlusIn} = 7'h0;
      {tokEp, dataLen, rxByte, rxIdx, txIdx} = 22'h0;
      tokType = USBL_TOK_SETUP;
      dMinusIn = 1'b1;
   end
   ////////////////////////////////////////
   // released fields invert so stale values fail
   task automatic tok(input usbl_tok_type t, input logic [3:0] ep);
      @(posedge sys_clk);
      {tokStb, tokType, tokEp} <= {1'b1, t, ep};
      @(posedge sys_clk);
      {tokStb, tokEp} <= {1'b0, ~ep};
   endtask
   // data phase with fault, toggle and length
   task automatic dat(input logic e, input logic t, input logic [3:0] n);
      @(posedge sys_clk);
      {dataStb, dataErr, dataToggle, dataLen} <= {1'b1, e, t, n};
      @(posedge sys_clk);
      {dataStb, dataErr, dataToggle, dataLen} <= {1'b0, ~e, ~t, ~n};
   endtask
   task automatic ack();
      @(posedge sys_clk);
      hostAck <= 1'b1;
      @(posedge sys_clk);
      hostAck <= 1'b0;
   endtask
   task automatic put(input logic [2:0] i, input logic [7:0] b);
      @(posedge sys_clk);
      {rxWr, rxIdx, rxByte} <= {1'b1, i, b};
      @(posedge sys_clk);
      {rxWr, rxByte} <= {1'b0, ~b};
   endtask
   task automatic sel(input logic [2:0] i);
      @(posedge sys_clk);
      txIdx <= i;
   endtask
   // line levels, idle is D+ low D- high
   task automatic pins(input logic p, input logic m);
      @(posedge sys_clk);
      {dPlusIn, dMinusIn} <= {p, m};
   endtask
endmodule

// file: usbl_pkg.sv
// shared constants and types for the low-speed endpoint control block
package usbl_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [7:0] USBL_ADDR_EP0_TX  = 8'h10;
   localparam logic [7:0] USBL_ADDR_EP1_TX  = 8'h11;
   localparam logic [7:0] USBL_ADDR_SCR     = 8'h13;
   localparam logic [7:0] USBL_RESET_VALUE  = 8'h00;
   localparam logic [7:0] USBL_SCR_MASK     = 8'h1f;
   localparam logic [7:0] USBL_READ_ZERO    = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // transmit configuration fields (both endpoints)
   localparam int USBL_CNT_LSB = 0;
   localparam int USBL_CNT_MSB = 3;
   localparam int USBL_ERR_BIT = 4;
   localparam int USBL_ON_BIT  = 4;
   localparam int USBL_STL_BIT = 5;
   localparam int USBL_TOG_BIT = 6;
   localparam int USBL_ARM_BIT = 7;

   // status and control fields
   localparam int USBL_ACT_BIT = 0;
   localparam int USBL_K_BIT   = 1;
   localparam int USBL_J_BIT   = 2;
   localparam int USBL_STA_BIT = 3;
   localparam int USBL_ACC_BIT = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // endpoint fifos in data memory
   localparam logic [3:0] USBL_FIFO_PAGE   = 4'h7;
   localparam logic [7:0] USBL_FIFO0_BASE  = 8'h70;
   localparam logic [7:0] USBL_FIFO1_BASE  = 8'h78;
   localparam int         USBL_FIFO_DEPTH  = 8;
   localparam int         USBL_FIFO_TOTAL  = 16;
   localparam logic [3:0] USBL_EP0         = 4'h0;
   localparam logic [3:0] USBL_EP1         = 4'h1;
   localparam logic [3:0] USBL_STATUS_LEN  = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // enumerations
   typedef enum logic [1:0] {
      USBL_TOK_SETUP = 2'h0,
      USBL_TOK_OUT   = 2'h1,
      USBL_TOK_IN    = 2'h2
   } usbl_tok_type;

   typedef enum logic [1:0] {
      USBL_RPL_ACK   = 2'h0,
      USBL_RPL_NAK   = 2'h1,
      USBL_RPL_STALL = 2'h2,
      USBL_RPL_DATA  = 2'h3
   } usbl_reply_type;

   typedef enum logic [1:0] {
      USBL_ST_IDLE     = 2'b00,
      USBL_ST_DATAWAIT = 2'b01,
      USBL_ST_ACKWAIT  = 2'b11
   } usbl_state_type;

endpackage
